// ===== src/ems_pkg.sv
package ems_pkg;
  // register map: the event status word sits at its 16-bit host address
  localparam logic [15:0] EVENT_STATUS_LOW_ADDR = 16'hE502;
  localparam logic [31:0] EVENT_STATUS_LOW_RST = 32'h0000_0000;
  // bits 31:19 never hold a flag
  localparam logic [31:0] RESERVED_MASK = 32'hFFF8_0000;

  // flag positions inside the event status word
  localparam int TOTAL_ACTIVE_HALF_FLAG = 0;
  localparam int FUND_ACTIVE_HALF_FLAG = 1;
  localparam int TOTAL_REACTIVE_HALF_FLAG = 2;
  localparam int FUND_REACTIVE_HALF_FLAG = 3;
  localparam int APPARENT_HALF_FLAG = 4;
  localparam int LINE_CYCLE_DONE_FLAG = 5;
  localparam int PHASE_ACTIVE_SIGN_FLAG0 = 6;
  localparam int SUM_ONE_SIGN_FLAG = 9;
  localparam int PHASE_REACTIVE_SIGN_FLAG0 = 10;
  localparam int SUM_TWO_SIGN_FLAG = 13;
  localparam int PULSE_FALL_FLAG0 = 14;
  localparam int DSP_CYCLE_DONE_FLAG = 17;
  localparam int SUM_THREE_SIGN_FLAG = 18;

  // field positions inside the power sign register
  localparam int PHASE_ACTIVE_SIGN0 = 0;
  localparam int SUM_ONE_SIGN = 3;
  localparam int PHASE_REACTIVE_SIGN0 = 4;
  localparam int SUM_TWO_SIGN = 7;
  localparam int SUM_THREE_SIGN = 8;
  localparam logic [8:0] POWER_SIGN_RST = 9'h000;

  // pulse selector field width and the idle level of a pulse pin
  localparam int PULSE_SEL_W = 3;
  localparam logic PULSE_IDLE = 1'b1;
endpackage

// ===== src/ems_pulse_tap.sv
`timescale 1ns/100ps
// one pulse output: picks the power type, drives the pin, reports falling edges
module ems_pulse_tap #(
  parameter int NSRC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NSRC-1:0] sources,
  input wire logic [ems_pkg::PULSE_SEL_W-1:0] sel,
  input wire logic dis,
  output logic pin,
  output logic fall
);
  typedef struct packed {
    logic last;
    logic pin;
  } ems_tap_state_t;

  ems_tap_state_t q;
  ems_tap_state_t d;
  logic cur;

  // the chosen source drives the pin unless disabled; the edge is seen regardless
  always_comb begin
    cur = sources[sel]; // R13
    d.last = cur;
    d.pin = dis ? ems_pkg::PULSE_IDLE : cur;
  end

  // last starts idle, so a source already low at the release of reset reads as a falling edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q.last <= ems_pkg::PULSE_IDLE;
      q.pin <= ems_pkg::PULSE_IDLE;
    end else begin
      q <= d;
    end
  end

  assign fall = q.last & ~cur; // R12
  assign pin = q.pin;

  property p_pin_follows;
    @(posedge clk) disable iff (!rst_n)
      !dis |=> pin == $past(cur);
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pulse pin ignores selected source"); // R13
endmodule // ems_pulse_tap

// ===== src/ems_event_status.sv
`timescale 1ns/100ps
// How it works
// R01 - bit 0 sets when bit 30 of any total active energy changes.
// R02 - bit 1 sets on fundamental active bit 30 change; zero without fundamental.
// R03 - bit 2 sets on total reactive bit 30 change; zero without reactive.
// R04 - bit 3 sets on fundamental reactive bit 30 change; zero without fundamental.
// R05 - bit 4 sets when bit 30 of any apparent energy changes.
// R06 - bit 5 sets at end of line-cycle integration in line-cycle mode.
// R07 - bits 6-8 flag active power sign flips; sign kept in bits 0-2.
// R08 - bits 10-12 flag reactive power sign flips; sign kept in bits 4-6.
// R09 - bit 9 flags sign flip of first pulse path sum; sign bit 3.
// R10 - bit 13 flags sign flip of second pulse path sum; sign bit 7.
// R11 - bit 18 flags sign flip of third pulse path sum; sign bit 8.
// R12 - bits 14-16 set on pulse falling edges, even when pin disabled.
// R13 - each pulse output carries the power type its selector picks.
// R14 - bit 17 sets when the periodic dsp cycle completes.
// R15 - bits 31:19 always read zero.
// R16 - flags hold until host writes one; writing zero changes nothing.
// R17 - event in same cycle as its clear keeps the flag set.
module ems_event_status #(
  parameter bit HAS_FUND = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1,
  parameter int NSRC = 8
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [2:0] TOTAL_ACTIVE_B30,
  input wire logic [2:0] FUND_ACTIVE_B30,
  input wire logic [2:0] TOTAL_REACTIVE_B30,
  input wire logic [2:0] FUND_REACTIVE_B30,
  input wire logic [2:0] APPARENT_B30,
  input wire logic LINE_CYCLE_MODE,
  input wire logic LINE_CYCLE_END,
  input wire logic ACTIVE_SIGN_SOURCE_SELECT,
  input wire logic REACTIVE_SIGN_SOURCE_SELECT,
  input wire logic [2:0] TOTAL_ACTIVE_NEG,
  input wire logic [2:0] FUND_ACTIVE_NEG,
  input wire logic [2:0] TOTAL_REACTIVE_NEG,
  input wire logic [2:0] FUND_REACTIVE_NEG,
  input wire logic [2:0] SUM_NEG,
  input wire logic [NSRC-1:0] PULSE_SOURCES_N,
  input wire logic [3*ems_pkg::PULSE_SEL_W-1:0] PULSE_SOURCE_SEL,
  input wire logic [2:0] PULSE_DISABLE,
  output logic [2:0] PULSE_OUT_N,
  input wire logic DSP_CYCLE_END,
  output logic [31:0] EVENT_STATUS_LOW,
  output logic [8:0] POWER_SIGN
);
  typedef struct packed {
    logic armed;
    logic [2:0] tae;
    logic [2:0] fae;
    logic [2:0] tre;
    logic [2:0] fre;
    logic [2:0] ape;
    logic [31:0] status;
    logic [8:0] sign;
    logic [31:0] rdata;
  } ems_state_t;

  ems_state_t q;
  ems_state_t d;
  logic [31:0] ev;
  logic [31:0] clr;
  logic [31:0] keep;
  logic [2:0] act_sign;
  logic [2:0] react_sign;
  logic [2:0] fall;

  // single address decode shared by the read and the write path
  function automatic logic hit(input logic [15:0] addr);
    hit = (addr == ems_pkg::EVENT_STATUS_LOW_ADDR);
  endfunction

  // three pulse taps, one per output, each with its own 3-bit selector
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tap
      ems_pulse_tap #(
        .NSRC(NSRC)
      ) u_tap (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .sources(PULSE_SOURCES_N),
        .sel(PULSE_SOURCE_SEL[gi*ems_pkg::PULSE_SEL_W +: ems_pkg::PULSE_SEL_W]), // R13
        .dis(PULSE_DISABLE[gi]),
        .pin(PULSE_OUT_N[gi]),
        .fall(fall[gi])
      );
    end
  endgenerate

  // sign sources follow the accumulation mode selects; only a missing reactive measurement reads positive
  always_comb begin
    act_sign = ACTIVE_SIGN_SOURCE_SELECT ? FUND_ACTIVE_NEG : TOTAL_ACTIVE_NEG; // R07
    react_sign = REACTIVE_SIGN_SOURCE_SELECT ? FUND_REACTIVE_NEG : TOTAL_REACTIVE_NEG; // R08
    if (!HAS_REACTIVE) begin
      react_sign = 3'h0;
    end
  end

  // event collection; comparisons wait one cycle after reset for a baseline
  always_comb begin
    ev = 32'h0000_0000;
    ev[ems_pkg::TOTAL_ACTIVE_HALF_FLAG] = q.armed & |(TOTAL_ACTIVE_B30 ^ q.tae); // R01
    ev[ems_pkg::FUND_ACTIVE_HALF_FLAG] =
      HAS_FUND & q.armed & |(FUND_ACTIVE_B30 ^ q.fae); // R02
    ev[ems_pkg::TOTAL_REACTIVE_HALF_FLAG] =
      HAS_REACTIVE & q.armed & |(TOTAL_REACTIVE_B30 ^ q.tre); // R03
    ev[ems_pkg::FUND_REACTIVE_HALF_FLAG] =
      HAS_FUND & HAS_REACTIVE & q.armed & |(FUND_REACTIVE_B30 ^ q.fre); // R04
    ev[ems_pkg::APPARENT_HALF_FLAG] = q.armed & |(APPARENT_B30 ^ q.ape); // R05
    ev[ems_pkg::LINE_CYCLE_DONE_FLAG] = LINE_CYCLE_MODE & LINE_CYCLE_END; // R06
    for (int i = 0; i < 3; i++) begin
      ev[ems_pkg::PHASE_ACTIVE_SIGN_FLAG0 + i] =
        q.armed & (act_sign[i] ^ q.sign[ems_pkg::PHASE_ACTIVE_SIGN0 + i]); // R07
      ev[ems_pkg::PHASE_REACTIVE_SIGN_FLAG0 + i] =
        q.armed & (react_sign[i] ^ q.sign[ems_pkg::PHASE_REACTIVE_SIGN0 + i]); // R08
      ev[ems_pkg::PULSE_FALL_FLAG0 + i] = fall[i]; // R12
    end
    ev[ems_pkg::SUM_ONE_SIGN_FLAG] = q.armed & (SUM_NEG[0] ^ q.sign[ems_pkg::SUM_ONE_SIGN]); // R09
    ev[ems_pkg::SUM_TWO_SIGN_FLAG] = q.armed & (SUM_NEG[1] ^ q.sign[ems_pkg::SUM_TWO_SIGN]); // R10
    ev[ems_pkg::SUM_THREE_SIGN_FLAG] =
      q.armed & (SUM_NEG[2] ^ q.sign[ems_pkg::SUM_THREE_SIGN]); // R11
    ev[ems_pkg::DSP_CYCLE_DONE_FLAG] = DSP_CYCLE_END; // R14
  end

  // write-one-to-clear; the event term is or-ed in last so a clash keeps the flag
  always_comb begin
    clr = (REG_WR && hit(REG_ADDR)) ? REG_WDATA : 32'h0000_0000; // R16
    keep = q.status & ~clr; // R16
    d = q;
    d.armed = 1'b1;
    d.tae = TOTAL_ACTIVE_B30;
    d.fae = FUND_ACTIVE_B30;
    d.tre = TOTAL_REACTIVE_B30;
    d.fre = FUND_REACTIVE_B30;
    d.ape = APPARENT_B30;
    d.status = (keep | ev) & ~ems_pkg::RESERVED_MASK; // R17 R15
    d.sign = {SUM_NEG[2], SUM_NEG[1], react_sign, SUM_NEG[0], act_sign}; // R07 R08 R09 R10 R11
    if (REG_RD) begin
      d.rdata = hit(REG_ADDR) ? q.status : 32'h0000_0000; // unmapped reads answer zero
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      q.armed <= 1'b0;
      q.tae <= 3'h0;
      q.fae <= 3'h0;
      q.tre <= 3'h0;
      q.fre <= 3'h0;
      q.ape <= 3'h0;
      q.status <= ems_pkg::EVENT_STATUS_LOW_RST;
      q.sign <= ems_pkg::POWER_SIGN_RST;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign EVENT_STATUS_LOW = q.status;
  assign POWER_SIGN = q.sign;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_act_flip;
    q.armed && (act_sign[0] != q.sign[ems_pkg::PHASE_ACTIVE_SIGN0]);
  endsequence
  sequence s_clash;
    REG_WR && hit(REG_ADDR) && REG_WDATA[ems_pkg::DSP_CYCLE_DONE_FLAG] && DSP_CYCLE_END;
  endsequence
  sequence s_clean_clear;
    REG_WR && hit(REG_ADDR) && REG_WDATA[ems_pkg::LINE_CYCLE_DONE_FLAG]
      && !(LINE_CYCLE_MODE && LINE_CYCLE_END);
  endsequence

  property p_total_active_half;
    q.armed && (TOTAL_ACTIVE_B30 != q.tae) |=> q.status[ems_pkg::TOTAL_ACTIVE_HALF_FLAG];
  endproperty
  a_total_active_half: assert property (p_total_active_half) else $error("active half missed"); // R01

  property p_fund_absent;
    !HAS_FUND |-> !q.status[ems_pkg::FUND_ACTIVE_HALF_FLAG]
      && !q.status[ems_pkg::FUND_REACTIVE_HALF_FLAG];
  endproperty
  a_fund_absent: assert property (p_fund_absent) else $error("fund flag without fund"); // R02

  // the flag must show on the next cycle and only a host clear may take it away the cycle after
  property p_line_cycle;
    LINE_CYCLE_MODE && LINE_CYCLE_END |=> q.status[ems_pkg::LINE_CYCLE_DONE_FLAG]
      ##1 (q.status[ems_pkg::LINE_CYCLE_DONE_FLAG]
      || $past(clr[ems_pkg::LINE_CYCLE_DONE_FLAG]));
  endproperty
  a_line_cycle: assert property (p_line_cycle) else $error("line cycle flag missed"); // R06

  property p_active_sign;
    s_act_flip |=> q.status[ems_pkg::PHASE_ACTIVE_SIGN_FLAG0]
      && (POWER_SIGN[ems_pkg::PHASE_ACTIVE_SIGN0] == $past(act_sign[0]));
  endproperty
  a_active_sign: assert property (p_active_sign) else $error("active sign flip lost"); // R07

  property p_pulse_fall;
    fall[0] |=> q.status[ems_pkg::PULSE_FALL_FLAG0];
  endproperty
  a_pulse_fall: assert property (p_pulse_fall) else $error("pulse edge not flagged"); // R12

  property p_reserved;
    REG_RD |=> REG_RDATA[31:19] == 13'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // R15

  property p_hold;
    1'b1 |=> ($past(keep) & ~q.status) == 32'h0000_0000;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear"); // R16

  property p_clear;
    s_clean_clear |=> !q.status[ems_pkg::LINE_CYCLE_DONE_FLAG];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear"); // R16

  property p_clash;
    s_clash |=> q.status[ems_pkg::DSP_CYCLE_DONE_FLAG];
  endproperty
  a_clash: assert property (p_clash) else $error("event lost under clear"); // R17

  property p_sum_two;
    q.armed && (SUM_NEG[1] != q.sign[ems_pkg::SUM_TWO_SIGN])
      |=> q.status[ems_pkg::SUM_TWO_SIGN_FLAG]
      && POWER_SIGN[ems_pkg::SUM_TWO_SIGN] == $past(SUM_NEG[1]);
  endproperty
  a_sum_two: assert property (p_sum_two) else $error("sum two flip lost"); // R10
endmodule // ems_event_status

// ===== verif/ems_host.sv
`timescale 1ns/100ps
// host side of the flag port: one strobe edge per access
module ems_host (
  input wire logic clk,
  output logic [15:0] addr,
  output logic wr,
  output logic [31:0] wdata,
  output logic rd,
  input wire logic [31:0] rdata
);
  initial begin
    addr = 16'hE502;
    wr = 1'b0;
    wdata = 32'h0000_0000;
    rd = 1'b0;
  end

  // ones clear, zeros keep; data shows its inverse once released
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // read word is loaded by the edge that samples the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule // ems_host

// ===== verif/ems_event_status_tb.sv
`timescale 1ns/100ps
// bench: an integer image of the flag word follows every stimulus
module ems_event_status_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] ta = 3'h0, fa = 3'h0, tr = 3'h0, fr = 3'h0, ap = 3'h0, pout, pe;
  logic [2:0] tan = 3'h0, fan = 3'h0, trn = 3'h0, frn = 3'h0, sn = 3'h0, dis = 3'h0;
  logic lcm = 1'b0, lce = 1'b0, dsp = 1'b0, asel = 1'b0, rsel = 1'b0, wr, rd;
  logic [7:0] src = 8'hFF;
  logic [8:0] psel = 9'h000, psign, psign2;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, st, v, st2;
  int exp_st = 0, error_cnt = 0, n_tests = 0;

  initial forever #5 clk = ~clk;

  ems_event_status dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
    .TOTAL_ACTIVE_B30(ta), .FUND_ACTIVE_B30(fa), .TOTAL_REACTIVE_B30(tr),
    .FUND_REACTIVE_B30(fr), .APPARENT_B30(ap), .LINE_CYCLE_MODE(lcm),
    .LINE_CYCLE_END(lce), .ACTIVE_SIGN_SOURCE_SELECT(asel),
    .REACTIVE_SIGN_SOURCE_SELECT(rsel), .TOTAL_ACTIVE_NEG(tan),
    .FUND_ACTIVE_NEG(fan), .TOTAL_REACTIVE_NEG(trn), .FUND_REACTIVE_NEG(frn),
    .SUM_NEG(sn), .PULSE_SOURCES_N(src), .PULSE_SOURCE_SEL(psel),
    .PULSE_DISABLE(dis), .PULSE_OUT_N(pout), .DSP_CYCLE_END(dsp),
    .EVENT_STATUS_LOW(st), .POWER_SIGN(psign));

  // reduced variant: no fundamental and no reactive measurement, same stimulus
  ems_event_status #(.HAS_FUND(1'b0), .HAS_REACTIVE(1'b0)) dut_lite_u (.CORE_CLK(clk),
    .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
    .REG_RDATA(), .TOTAL_ACTIVE_B30(ta), .FUND_ACTIVE_B30(fa), .TOTAL_REACTIVE_B30(tr),
    .FUND_REACTIVE_B30(fr), .APPARENT_B30(ap), .LINE_CYCLE_MODE(lcm),
    .LINE_CYCLE_END(lce), .ACTIVE_SIGN_SOURCE_SELECT(asel),
    .REACTIVE_SIGN_SOURCE_SELECT(rsel), .TOTAL_ACTIVE_NEG(tan),
    .FUND_ACTIVE_NEG(fan), .TOTAL_REACTIVE_NEG(trn), .FUND_REACTIVE_NEG(frn),
    .SUM_NEG(sn), .PULSE_SOURCES_N(src), .PULSE_SOURCE_SEL(psel),
    .PULSE_DISABLE(dis), .PULSE_OUT_N(), .DSP_CYCLE_END(dsp),
    .EVENT_STATUS_LOW(st2), .POWER_SIGN(psign2));

  ems_host host_u (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // flag word read back against the image
  task automatic rchk();
    host_u.rd_reg(16'hE502, v);
    chk(v, exp_st);
  endtask

  // sign word against the selected sources; the reduced variant keeps reactive signs zero
  task automatic schk();
    logic [31:0] w;
    w = {23'h0, sn[2], sn[1], (rsel ? frn : trn), sn[0], (asel ? fan : tan)};
    chk({23'h0, psign}, w);
    w[6:4] = 3'h0;
    chk({23'h0, psign2}, w);
  endtask

  task automatic wclr(input logic [31:0] d);
    host_u.wr_reg(16'hE502, d);
    exp_st &= ~d;
  endtask

  // raise the cause of flag b; pulses last one edge
  task automatic kick(input int b);
    int p;
    int s;
    p = $urandom % 3;
    s = $urandom % 8;
    @(posedge clk);
    case (b)
      0: ta[p] <= ~ta[p];
      1: fa[p] <= ~fa[p];
      2: tr[p] <= ~tr[p];
      3: fr[p] <= ~fr[p];
      4: ap[p] <= ~ap[p];
      5: lce <= 1'b1;
      6, 7, 8: if (asel) fan[b-6] <= ~fan[b-6]; else tan[b-6] <= ~tan[b-6];
      10, 11, 12: if (rsel) frn[b-10] <= ~frn[b-10]; else trn[b-10] <= ~trn[b-10];
      9: sn[0] <= ~sn[0];
      13: sn[1] <= ~sn[1];
      18: sn[2] <= ~sn[2];
      14, 15, 16: begin
        psel[3*(b-14) +: 3] <= 3'(s);
        dis <= 3'($urandom);
        @(posedge clk);
        src[s] <= 1'b0;
      end
      default: dsp <= 1'b1;
    endcase
    @(posedge clk);
    lce <= 1'b0;
    dsp <= 1'b0;
    src <= 8'hFF;
    #1;
    // every output sharing the source flags a fall, disabled or not; disabled pins stay high
    if (b >= 14 && b <= 16) begin
      for (int j = 0; j < 3; j++) begin
        pe[j] = dis[j] | (psel[3*j +: 3] != 3'(s));
        if (psel[3*j +: 3] == 3'(s)) exp_st |= 32'h1 << (14 + j);
      end
      chk({29'h0, pout}, {29'h0, pe});
    end else if (b != 5 || lcm) exp_st |= 32'h1 << b;
  endtask

  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h633d75da));
    {asel, rsel} <= 2'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk();
    chk({29'h0, pout}, 32'h7);
    kick(5);
    rchk();
    @(posedge clk);
    lcm <= 1'b1;
    for (int b = 0; b < 19; b++) begin
      kick(b);
      repeat (2) @(posedge clk);
      schk();
      chk(st, exp_st);
      chk(st2, exp_st & ~32'h0000_1C0E);
      rchk();
      wclr(~(32'h1 << b));
      rchk();
      wclr(32'h1 << b);
      rchk();
    end
    // swapping both sign sources flags every phase whose two sources disagree
    @(posedge clk);
    asel <= ~asel;
    rsel <= ~rsel;
    repeat (2) @(posedge clk);
    exp_st |= ({29'h0, tan ^ fan} << 6) | ({29'h0, trn ^ frn} << 10);
    schk();
    chk(st, exp_st);
    chk(st2, exp_st & ~32'h0000_1C0E);
    // other addresses neither clear nor read back
    kick(4);
    host_u.wr_reg(16'hE503, 32'hFFFF_FFFF);
    host_u.rd_reg(16'hE503, v);
    chk(v, 32'h0);
    rchk();
    // clear meeting a fresh event keeps the flag
    kick(17);
    fork
      kick(17);
      host_u.wr_reg(16'hE502, 32'h0002_0000);
    join
    exp_st |= 32'h0002_0000;
    rchk();
    stop_test();
  end
endmodule // ems_event_status_tb
